/* hw/ste_pkg.sv */
// Constants shared by the serial transfer engine files.
// Contract
// - Data read gives receive buffer; write fills transmit
// - Master transfer starts on transmit buffer load
// - Full receive buffer keeps old byte, drops new
// - No overrun flag exists anywhere
// - Free shifter takes queued byte, sets room, shifts
// - Eight clock cycles, byte out and in together
// - End moves byte to receive buffer, next starts
// - Most significant first unless low bit first set
// - Polarity inverts clock, phase picks data relation
// - Phase one: select leads half cycle, ends bit eight
// - Phase zero: select at bit one, lags half cycle
// - Phase one: odd edges shift, even edges sample
// - Phase zero: first bit on select, edge samples
// - Interrupt from masked receive, fault, transmit flags
// - Select pin is fault input in master only
// - Fault sets flag, drops master, disables drivers; code turns off clock, data and select drivers but drives miso while select low
// - Fault clears after status read then control write
// - Receive flag clears after status then data read
// - Data write needs prior status read with room
// - Clock rate is bus over prescale and divisor
package ste_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int BYTE_W = 8;
  localparam int CNT_W  = 5;
  localparam int RATE_W = 11;

  localparam logic [ADDR_W-1:0] OFS_CTRL1  = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CTRL2  = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_BAUD   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DATA   = 8'h10;

  // Control one fields.
  localparam int RX_MASK_BIT = 7;
  localparam int TX_MASK_BIT = 5;
  localparam int MASTER_BIT  = 4;
  localparam int CPOL_BIT    = 3;
  localparam int CPHA_BIT    = 2;
  localparam int SELECT_OUTPUT_ENABLE_BIT    = 1;
  localparam int LSBF_BIT    = 0;
  // Control two, rate and status fields.
  localparam int MODE_FAULT_ENABLE_BIT  = 4;
  localparam int PRESC_LSB   = 4;
  localparam int DIVIS_LSB   = 0;
  localparam int RXF_BIT     = 7;
  localparam int TXR_BIT     = 5;
  localparam int FAULT_BIT   = 4;

  localparam logic [CNT_W-1:0] EDGE_LAST = 5'h10;
  localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
  localparam logic [3:0]       PIN_INIT  = 4'h8;
endpackage : ste_pkg

/* hw/ste_sync.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module ste_sync #(
  parameter int           W    = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } ste_sync_type;

  ste_sync_type r;
  ste_sync_type next_r;

  always_comb begin
    next_r    = r;
    next_r.s1 = d;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    // A bit changes only once the second and third stages agree.
    for (int i = 0; i < W; i++) begin
      if (r.s2[i] == r.s3[i]) begin
        next_r.f[i] = r.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= {INIT, INIT, INIT, INIT};
    end else begin
      r <= next_r;
    end
  end

  assign q = r.f;
endmodule : ste_sync

/* hw/ste_rate.sv */
// Half-period tick generator for the master shift clock.
`timescale 1ns/1ps
module ste_rate
  import ste_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] prescale,
  input  wire logic [2:0] divisor,
  output logic            tick
);
  typedef struct packed {
    logic [RATE_W-1:0] cnt;
    logic              tick;
  } ste_rate_type;

  ste_rate_type     r;
  ste_rate_type     next_r;
  logic [RATE_W-1:0] half;

  always_comb begin
    // Half period is prescale plus one, times two to the power of the divisor.
    half        = RATE_W'(({8'h00, prescale} + 11'h001) << divisor);
    next_r      = r;
    next_r.tick = 1'b0;
    if (!run) begin
      next_r.cnt = '0;
    end else if (r.cnt == half - 11'h001) begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;
    end else begin
      next_r.cnt = r.cnt + 11'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick = r.tick;
endmodule : ste_rate

/* hw/ste_top.sv */
// Serial peripheral transfer engine with APB register access.
`timescale 1ns/1ps
module ste_top (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ste_pkg::ADDR_W-1:0] paddr,
  input  wire logic [ste_pkg::DATA_W-1:0] pwdata,
  output logic      [ste_pkg::DATA_W-1:0] prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  input  wire logic                       sck_i,
  output logic                            sck_o,
  output logic                            sck_oe,
  input  wire logic                       mosi_i,
  output logic                            mosi_o,
  output logic                            mosi_oe,
  input  wire logic                       miso_i,
  output logic                            miso_o,
  output logic                            miso_oe,
  input  wire logic                       ss_n_i,
  output logic                            ss_n_o,
  output logic                            ss_n_oe
);
  import ste_pkg::*;

  typedef struct packed {
    logic              rx_mask;
    logic              tx_mask;
    logic              master;
    logic              cpol;
    logic              cpha;
    logic              select_output_enable;
    logic              lsbf;
    logic              mode_fault_enable;
    logic [2:0]        presc;
    logic [2:0]        divis;
    logic [BYTE_W-1:0] tx_buf;
    logic [BYTE_W-1:0] rx_buf;
    logic              tx_room;
    logic              rx_full;
    logic              fault;
    logic              arm_tx;
    logic              arm_rx;
    logic              arm_fault;
    logic [BYTE_W-1:0] sh;
    logic              samp;
    logic              out_bit;
    logic              busy;
    logic [CNT_W-1:0]  cnt;
    logic              sck;
    logic              sck_prev;
    logic              ss_n;
    logic [DATA_W-1:0] prdata;
    logic              pready;
    logic              pslverr;
    logic              irq;
    logic              sck_oe;
    logic              mosi_oe;
    logic              miso_oe;
    logic              ss_oe;
  } ste_state_type;

  ste_state_type q;
  ste_state_type next_q;
  logic          tick;
  logic          ss_f;
  logic          sck_f;
  logic          mosi_f;
  logic          miso_f;
  logic          access;
  logic          edge_ev;
  logic          done;
  logic          bit_in;
  logic          fault_cond;

  function automatic logic end_bit(logic [BYTE_W-1:0] v, logic lsb);
    end_bit = lsb ? v[0] : v[BYTE_W-1];
  endfunction : end_bit

  function automatic logic [BYTE_W-1:0] shift_in(logic [BYTE_W-1:0] v,
                                                 logic lsb, logic b);
    shift_in = lsb ? {b, v[BYTE_W-1:1]} : {v[BYTE_W-2:0], b};
  endfunction : shift_in

  ////////////////////////////////////////////////////////////////////////////
  ste_sync #(
    .W    (4),
    .INIT (PIN_INIT)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .d   ({ss_n_i, sck_i, mosi_i, miso_i}),
    .q   ({ss_f, sck_f, mosi_f, miso_f})
  );

  ste_rate u_rate (
    .clk      (clk),
    .rst      (rst),
    .run      (q.busy & q.master),
    .prescale (q.presc),
    .divisor  (q.divis),
    .tick     (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_q     = q;
    done       = 1'b0;
    edge_ev    = 1'b0;
    bit_in     = q.master ? miso_f : mosi_f;
    fault_cond = q.master & q.mode_fault_enable & ~q.select_output_enable & ~ss_f;
    access     = psel & penable & q.pready & ~q.pslverr;

    // Setup phase: decode and capture read data for the access phase.
    next_q.pready = psel & ~penable;
    if (psel && !penable) begin
      next_q.pslverr = 1'b0;
      next_q.prdata  = '0;
      unique case (paddr)
        OFS_CTRL1: begin
          next_q.prdata[RX_MASK_BIT] = q.rx_mask;
          next_q.prdata[TX_MASK_BIT] = q.tx_mask;
          next_q.prdata[MASTER_BIT]  = q.master;
          next_q.prdata[CPOL_BIT]    = q.cpol;
          next_q.prdata[CPHA_BIT]    = q.cpha;
          next_q.prdata[SELECT_OUTPUT_ENABLE_BIT]    = q.select_output_enable;
          next_q.prdata[LSBF_BIT]    = q.lsbf;
        end
        OFS_CTRL2: next_q.prdata[MODE_FAULT_ENABLE_BIT] = q.mode_fault_enable;
        OFS_BAUD: begin
          next_q.prdata[PRESC_LSB +: 3] = q.presc;
          next_q.prdata[DIVIS_LSB +: 3] = q.divis;
        end
        OFS_STATUS: begin
          next_q.prdata[RXF_BIT]   = q.rx_full;
          next_q.prdata[TXR_BIT]   = q.tx_room;
          next_q.prdata[FAULT_BIT] = q.fault;
        end
        OFS_DATA: next_q.prdata[BYTE_W-1:0] = q.rx_buf;
        default: next_q.pslverr = 1'b1;
      endcase
    end

    // Read side effects use the value that the read returned.
    if (access && !pwrite) begin
      if (paddr == OFS_STATUS) begin
        next_q.arm_rx    = q.prdata[RXF_BIT];
        next_q.arm_tx    = q.prdata[TXR_BIT];
        next_q.arm_fault = q.prdata[FAULT_BIT];
      end
      if (paddr == OFS_DATA && q.arm_rx) begin
        next_q.rx_full = 1'b0;
        next_q.arm_rx  = 1'b0;
      end
    end
    if (access && pwrite) begin
      unique case (paddr)
        OFS_CTRL1: begin
          next_q.rx_mask = pwdata[RX_MASK_BIT];
          next_q.tx_mask = pwdata[TX_MASK_BIT];
          next_q.master  = pwdata[MASTER_BIT];
          next_q.cpol    = pwdata[CPOL_BIT];
          next_q.cpha    = pwdata[CPHA_BIT];
          next_q.select_output_enable    = pwdata[SELECT_OUTPUT_ENABLE_BIT];
          next_q.lsbf    = pwdata[LSBF_BIT];
          if (q.arm_fault) begin
            next_q.fault     = 1'b0;
            next_q.arm_fault = 1'b0;
          end
        end
        OFS_CTRL2: next_q.mode_fault_enable = pwdata[MODE_FAULT_ENABLE_BIT];
        OFS_BAUD: begin
          next_q.presc = pwdata[PRESC_LSB +: 3];
          next_q.divis = pwdata[DIVIS_LSB +: 3];
        end
        OFS_DATA: begin
          // Without a prior status read showing room the write is dropped.
          if (q.arm_tx) begin
            next_q.tx_buf  = pwdata[BYTE_W-1:0];
            next_q.tx_room = 1'b0;
            next_q.arm_tx  = 1'b0;
          end
        end
        default: next_q.pslverr = 1'b0;
      endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Master: ticks are half periods; sixteen edges, then one closing tick.
    next_q.sck_prev = sck_f;
    if (q.master) begin
      if (!q.busy) begin
        next_q.sck = next_q.cpol;
        if (!q.tx_room && !fault_cond) begin
          next_q.sh      = q.tx_buf;
          next_q.tx_room = 1'b1;
          next_q.busy    = 1'b1;
          next_q.cnt     = CNT_ZERO;
          next_q.ss_n    = 1'b0;
          next_q.out_bit = end_bit(q.tx_buf, q.lsbf);
        end
      end else if (tick) begin
        if (q.cnt == EDGE_LAST) begin
          done = 1'b1;
        end else begin
          edge_ev    = 1'b1;
          next_q.sck = ~q.sck;
        end
      end
    end else begin
      if (ss_f) begin
        next_q.cnt = CNT_ZERO;
      end else if (sck_f != q.sck_prev && q.cnt != EDGE_LAST) begin
        edge_ev = 1'b1;
      end
      if (q.cnt == CNT_ZERO) begin
        if (!q.tx_room) begin
          next_q.sh      = q.tx_buf;
          next_q.tx_room = 1'b1;
        end
        if (!q.cpha) begin
          next_q.out_bit = end_bit(q.sh, q.lsbf);
        end
      end
    end

    // Odd edges sample (phase zero) or drive (phase one); even edges shift.
    if (edge_ev) begin
      next_q.cnt = q.cnt + CNT_ONE;
      if (!q.cnt[0]) begin
        if (!q.cpha) begin
          next_q.samp = bit_in;
        end else begin
          next_q.out_bit = end_bit(q.sh, q.lsbf);
        end
      end else begin
        next_q.sh = shift_in(q.sh, q.lsbf, q.cpha ? bit_in : q.samp);
        if (!q.cpha) begin
          next_q.out_bit = end_bit(next_q.sh, q.lsbf);
        end
        if (!q.master && q.cnt == EDGE_LAST - CNT_ONE) begin
          done = 1'b1;
        end
      end
    end

    if (done) begin
      // A byte still unread wins; the new one is dropped silently.
      if (!next_q.rx_full) begin
        next_q.rx_buf  = next_q.sh;
        next_q.rx_full = 1'b1;
      end
      next_q.cnt  = CNT_ZERO;
      next_q.busy = 1'b0;
      next_q.ss_n = 1'b1;
    end

    if (fault_cond) begin
      next_q.fault  = 1'b1;
      next_q.master = 1'b0;
    end
    if (next_q.master != q.master) begin
      next_q.cnt  = CNT_ZERO;
      next_q.busy = 1'b0;
      next_q.ss_n = 1'b1;
    end

    next_q.sck_oe  = next_q.master;
    next_q.mosi_oe = next_q.master;
    next_q.miso_oe = ~next_q.master & ~ss_f;
    next_q.ss_oe   = next_q.master & next_q.mode_fault_enable & next_q.select_output_enable;
    next_q.irq     = ((next_q.rx_full | next_q.fault) & next_q.rx_mask)
                   | (next_q.tx_room & next_q.tx_mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q         <= '0;
      q.tx_room <= 1'b1;
      q.ss_n    <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign irq     = q.irq;
  assign sck_o   = q.sck;
  assign sck_oe  = q.sck_oe;
  assign mosi_o  = q.out_bit;
  assign mosi_oe = q.mosi_oe;
  assign miso_o  = q.out_bit;
  assign miso_oe = q.miso_oe;
  assign ss_n_o  = q.ss_n;
  assign ss_n_oe = q.ss_oe;

  ////////////////////////////////////////////////////////////////////////////
  rx_keep_a: assert property (@(posedge clk) disable iff (rst)
    done && q.rx_full && !(access && q.arm_rx) |=> $stable(q.rx_buf))
    else $error("receive buffer overwritten while full");

  tx_start_a: assert property (@(posedge clk) disable iff (rst)
    q.master && !q.busy && !q.tx_room && !fault_cond
    |=> q.busy && q.tx_room && !q.ss_n)
    else $error("master did not start a queued byte");

  sck_idle_a: assert property (@(posedge clk) disable iff (rst)
    q.master && !q.busy ##1 q.master && !q.busy |-> q.sck == q.cpol)
    else $error("idle shift clock not at polarity level");

  fault_drop_a: assert property (@(posedge clk) disable iff (rst)
    $rose(q.fault) |-> !q.master && !q.sck_oe && !q.mosi_oe)
    else $error("fault did not drop master drivers");

  fault_in_a: assert property (@(posedge clk) disable iff (rst)
    !fault_cond && !q.fault |=> !q.fault)
    else $error("fault set without a qualified select low");

  rx_clear_a: assert property (@(posedge clk) disable iff (rst)
    access && !pwrite && paddr == OFS_DATA && q.arm_rx && !done
    |=> !q.rx_full)
    else $error("receive flag not cleared by data read");

  data_drop_a: assert property (@(posedge clk) disable iff (rst)
    access && pwrite && paddr == OFS_DATA && !q.arm_tx
    |=> $stable(q.tx_buf))
    else $error("unarmed data write was accepted");

  xfer_len_a: assert property (@(posedge clk) disable iff (rst)
    done && q.master |-> q.cnt == EDGE_LAST && q.sck == q.cpol)
    else $error("master transfer ended off sixteen edges");

  irq_out_a: assert property (@(posedge clk) disable iff (rst)
    (q.rx_full || q.fault) && q.rx_mask ##1
    (q.rx_full || q.fault) && q.rx_mask |-> q.irq)
    else $error("masked receive flag gave no interrupt");
endmodule : ste_top

/* test/ste_slave_model.sv */
// Behavioural serial slave that answers the engine in master mode.
`timescale 1ns/1ps
module ste_slave_model (
  input  wire logic       sck,
  input  wire logic       ss_n,
  input  wire logic       mosi,
  input  wire logic       cpol,
  input  wire logic       cpha,
  input  wire logic       lsbf,
  input  wire logic [7:0] tx_byte,
  output logic            miso,
  output logic [7:0]      rx_byte,
  output int              done_cnt
);
  int         shifts;
  int         samples;
  logic [7:0] acc;

  // Every second byte goes out inverted so a dropped byte shows.
  function automatic logic pick(input int k);
    logic [7:0] v;
    v = tx_byte ^ {8{done_cnt[0]}};
    return lsbf ? v[k] : v[7-k];
  endfunction : pick

  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    done_cnt = 0;
    shifts = 0;
    samples = 0;
    acc = 8'h00;
  end

  always @(negedge ss_n) begin
    shifts = 0;
    samples = 0;
    if (!cpha) miso = pick(0);
  end

  // A released line shows the inverse of its last value.
  always @(posedge ss_n) miso = ~miso;

  always @(sck) begin
    if (!ss_n) begin
      if ((sck != cpol) != cpha) begin
        acc = lsbf ? {mosi, acc[7:1]} : {acc[6:0], mosi};
        samples++;
        if (samples == 8) begin
          rx_byte = acc;
          done_cnt++;
        end
      end else begin
        if (cpha) miso = (shifts < 8) ? pick(shifts) : ~miso;
        else miso = (shifts < 7) ? pick(shifts + 1) : ~miso;
        shifts++;
      end
    end
  end
endmodule : ste_slave_model

/* test/spi_transfer_engine_tb.sv */
// Self-checking bench for the serial transfer engine in master and slave mode.
`timescale 1ns/1ps
module spi_transfer_engine_tb;
  import ste_pkg::*;
  logic              clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata;
  logic              sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic              ss_n_o, ss_n_oe, ss_n_in, model_miso, cpol, cpha, lsbf;
  logic              sck_in, mosi_in;
  logic [7:0]        stx, srx;
  int                done_cnt, failures, compares;
  wire               sck_pin, mosi_pin, miso_pin, ss_n_pin;

  assign sck_pin  = sck_oe ? sck_o : sck_in;
  assign mosi_pin = mosi_oe ? mosi_o : mosi_in;
  assign miso_pin = miso_oe ? miso_o : model_miso;
  assign ss_n_pin = ss_n_oe ? ss_n_o : ss_n_in;

  ste_top ste_top_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .sck_i(sck_pin),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_pin), .mosi_o(mosi_o),
    .mosi_oe(mosi_oe), .miso_i(miso_pin), .miso_o(miso_o),
    .miso_oe(miso_oe), .ss_n_i(ss_n_pin), .ss_n_o(ss_n_o),
    .ss_n_oe(ss_n_oe));

  ste_slave_model ste_slave_model_i (.sck(sck_pin), .ss_n(ss_n_pin),
    .mosi(mosi_pin), .cpol(cpol), .cpha(cpha), .lsbf(lsbf), .tx_byte(stx),
    .miso(model_miso), .rx_byte(srx), .done_cnt(done_cnt));

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [DATA_W-1:0] got,
                     input logic [DATA_W-1:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] x);
    logic [DATA_W-1:0] r;
    logic              e;
    apb(1'b0, a, '0, r, e);
    chk(r, x);
  endtask : rd_chk

  task automatic wait_done(input int n);
    int k;
    k = 0;
    while (done_cnt < n && k < 4000) begin
      @(posedge clk);
      k++;
    end
    if (done_cnt < n) failures++;
  endtask : wait_done

  // Outside master swaps one phase-zero byte with the engine as a slave.
  task automatic ext_master(input logic [7:0] d, output logic [7:0] r);
    ss_n_in <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi_in <= d[i];
      repeat (8) @(posedge clk);
      r[i] = miso_oe ? miso_o : 1'bx;
      sck_in <= 1'b1;
      repeat (8) @(posedge clk);
      sck_in <= 1'b0;
    end
    repeat (8) @(posedge clk);
    ss_n_in <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : ext_master

  function automatic logic [DATA_W-1:0] ctrl_word(input logic p, input logic h,
                                                  input logic l);
    return (32'h1 << MASTER_BIT) | (32'(p) << CPOL_BIT) |
           (32'(h) << CPHA_BIT) | (32'h1 << SELECT_OUTPUT_ENABLE_BIT) | (32'(l) << LSBF_BIT);
  endfunction : ctrl_word

  function automatic logic [DATA_W-1:0] status_word(input logic rf,
                                                    input logic tr,
                                                    input logic mf);
    return (32'(rf) << RXF_BIT) | (32'(tr) << TXR_BIT) | (32'(mf) << FAULT_BIT);
  endfunction : status_word

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : stop_test

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    stop_test();
  end

  initial begin
    logic [DATA_W-1:0] r;
    logic              e;
    logic [7:0]        a, b, s;
    int                base;
    rst = 1'b1;
    sck_in = 1'b0;
    mosi_in = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    ss_n_in = 1'b1;
    cpol = 1'b0;
    cpha = 1'b0;
    lsbf = 1'b0;
    stx = 8'h00;
    failures = 0;
    compares = 0;
    void'($urandom(10275));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b0));
    rd_chk(OFS_DATA, 32'h0);
    // Each clock format with random data, a queued byte and an overrun.
    for (int m = 0; m < 4; m++) begin
      a = 8'($urandom);
      b = 8'($urandom);
      cpol <= m[1];
      cpha <= m[0];
      lsbf <= 1'($urandom);
      stx <= 8'($urandom);
      wr(OFS_BAUD, 32'h0000_0031);
      wr(OFS_CTRL2, 32'h1 << MODE_FAULT_ENABLE_BIT);
      wr(OFS_CTRL1, ctrl_word(m[1], m[0], lsbf));
      rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b0));
      base = done_cnt;
      wr(OFS_DATA, {24'h0, a});
      rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b0));
      wr(OFS_DATA, {24'h0, b});
      wr(OFS_DATA, {24'h0, ~a});
      wait_done(base + 1);
      chk({24'h0, srx}, {24'h0, a});
      wait_done(base + 2);
      chk({24'h0, srx}, {24'h0, b});
      repeat (300) @(posedge clk);
      chk(32'(done_cnt - base), 32'h2);
      chk({30'h0, sck_o, ss_n_o}, {30'h0, cpol, 1'b1});
      rd_chk(OFS_STATUS, status_word(1'b1, 1'b1, 1'b0));
      rd_chk(OFS_DATA, {24'h0, stx});
      rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b0));
    end
    wr(OFS_CTRL1, (32'h1 << TX_MASK_BIT) | (32'h1 << MASTER_BIT));
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_CTRL1, (32'h1 << RX_MASK_BIT) | (32'h1 << MASTER_BIT));
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    // Another master pulls select low while this one has no select output.
    ss_n_in <= 1'b0;
    repeat (8) @(posedge clk);
    rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b1));
    chk({30'h0, sck_oe, mosi_oe}, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd_chk(OFS_CTRL1, 32'h1 << RX_MASK_BIT);
    ss_n_in <= 1'b1;
    repeat (8) @(posedge clk);
    wr(OFS_CTRL1, 32'h0);
    rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b0));
    apb(1'b0, 8'h14, 32'h0, r, e);
    chk({31'h0, e}, 32'h1);
    chk(r, 32'h0);
    // Engine as a phase-zero slave: random bytes both ways.
    cpol <= 1'b0;
    cpha <= 1'b0;
    a = 8'($urandom);
    b = 8'($urandom);
    rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b0));
    wr(OFS_DATA, {24'h0, a});
    repeat (4) @(posedge clk);
    ext_master(b, s);
    chk({24'h0, s}, {24'h0, a});
    rd_chk(OFS_STATUS, status_word(1'b1, 1'b1, 1'b0));
    rd_chk(OFS_DATA, {24'h0, b});
    rd_chk(OFS_STATUS, status_word(1'b0, 1'b1, 1'b0));
    stop_test();
  end
endmodule : spi_transfer_engine_tb
